/* File: src/simd_consts.svh */
`ifndef SIMD_CONSTS_SVH
`define SIMD_CONSTS_SVH

// ************************************************
// Register offsets
// ************************************************
`define OFF_CTRL 12'h000
`define OFF_CMD 12'h004
`define OFF_STATUS 12'h008
`define OFF_INT_STAT 12'h00C
`define OFF_INT_MASK 12'h010
`define OFF_VCSR 12'h014
`define OFF_FEATURE 12'h018
`define OFF_FLAGS 12'h01C
`define OFF_TAG 12'h020
`define OFF_GPR_LO 12'h024
`define OFF_GPR_HI 12'h028
`define WIN_VREG 4'h4
`define WIN_PINT 6'h14
`define WIN_AREA 2'h2

// ************************************************
// Field positions
// ************************************************
`define CTRL_MODE_LSB 0
`define CTRL_WIDTH_BIT 3
`define CTRL_PREFIX_BIT 4
`define CTRL_SRC_A_LSB 8
`define CTRL_SRC_B_LSB 12
`define CMD_SAVE 0
`define CMD_RESTORE 1
`define CMD_COMPARE 2
`define CMD_MOVE 3
`define EV_SAVE 0
`define EV_RESTORE 1
`define EV_FAULT 2
`define EV_COMPARE 3
`define VCSR_DAZ 6
`define FEATURE_BIT 26
`define FLAG_CF 0
`define FLAG_PF 2
`define FLAG_ZF 6

// ************************************************
// Reset values and constant masks
// ************************************************
`define VCSR_RST 32'h00001F80
`define VCSR_LEGAL 32'h0000FFFF
`define FLAGS_RST 32'h00000002
`define FLAGS_CMP_MASK 32'h000008D5
`define FEATURE_VAL 32'h04000000

// ************************************************
// Save area word indices
// ************************************************
`define W_TAG 7'h01
`define W_VCSR 7'h06
`define W_VCSR_MASK 7'h07
`define W_PINT_FIRST 7'h08
`define W_VREG_FIRST 7'h28
`define W_VREG_HI 7'h48
`define W_LAST 7'h67

`endif

/* File: src/simd_pkg.sv */
package simd_pkg;

	typedef enum logic [2:0]
	{
		MODE_REAL = 3'h0,
		MODE_V86 = 3'h1,
		MODE_PROT = 3'h2,
		MODE_COMPAT = 3'h3,
		MODE_LONG64 = 3'h4
	} exec_mode_t;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_RUN = 2'b11,
		ST_DONE = 2'b10
	} eng_state_t;

	typedef enum logic [2:0]
	{
		RG_NONE = 3'h0,
		RG_REG = 3'h1,
		RG_VREG = 3'h2,
		RG_PINT = 3'h3,
		RG_AREA = 3'h4
	} region_t;

	typedef struct packed
	{
		logic en;
		logic [3:0] idx;
		logic [3:0] lanes;
		logic [127:0] data;
	} vreg_wr_t;

	typedef struct packed
	{
		logic en;
		logic [2:0] idx;
		logic [1:0] lanes;
		logic [63:0] data;
	} pint_wr_t;

	typedef struct packed
	{
		logic en;
		logic [7:0] idx;
		logic [31:0] data;
	} area_wr_t;

endpackage : simd_pkg

/* File: src/simd_state_save_restore.sv */
// Overview of operation
// - Save writes stack state and vector state into the addressed save area.
// - Restore loads state only when the control/status word at bytes 27:24 is legal.
// - Reserved bits set in that word raise a protection fault, nothing restored.
// - Feature query leaf 01H reports the second extension in bit 26.
// - Vector registers hold 128 bits; scalar doubles use the low quadword only.
// - A 32-bit control/status register holds denormals-are-zeros and flush-to-zero flags.
// - Eight 64-bit packed-integer registers, also feeding mixed operations with vector registers.
// - Addresses come only from general registers, never vector or packed-integer ones.
// - Scalar compare writes its outcome into the 32-bit flags register.
// - Vector registers 8 to 15 exist only in 64-bit mode, via the prefix; here bit 3 of a source field selects them there, prefix or not.
// - Compatibility mode behaves exactly like protected mode.
// - Prefix with width bit selects 64-bit general operands; meaningless prefix is ignored.
// - The extension works in protected, real-address and virtual-8086 modes alike.
// - The second extension adds no state; the same save and restore cover it.
// - Area bytes 415:288 are saved and restored only in 64-bit mode.
// - Abridged tag byte 4: bit j is zero when stack register j is empty.
//
// Chosen here: the APB interface to the registers and the register addresses.
`include "simd_consts.svh"

module simd_state_save_restore (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	import simd_pkg::*;

	// ************************************************
	// Helpers
	// ************************************************
	function automatic region_t decode(input logic [11:0] a);
		if (a[11:8] == `WIN_VREG)
			decode = RG_VREG;
		else if (a[11:6] == `WIN_PINT)
			decode = RG_PINT;
		else if (a[11:10] == `WIN_AREA)
			decode = RG_AREA;
		else if (a <= `OFF_GPR_HI && a[1:0] == 2'h0)
			decode = RG_REG;
		else
			decode = RG_NONE;
	endfunction : decode

	function automatic logic [3:0] lane_sel(input logic [1:0] q);
		lane_sel = 4'h1 << q;
	endfunction : lane_sel

	// Returns {zf, pf, cf}; unordered sets all three
	function automatic logic [2:0] cmp_sd(input logic [63:0] a, input logic [63:0] b,
		input logic daz);
		logic [62:0] ma;
		logic [62:0] mb;
		logic sa;
		logic sb;
		logic lt;
		ma = {a[62:52], (daz && a[62:52] == 11'h000) ? 52'h0 : a[51:0]};
		mb = {b[62:52], (daz && b[62:52] == 11'h000) ? 52'h0 : b[51:0]};
		sa = a[63] && ma != 63'h0;
		sb = b[63] && mb != 63'h0;
		lt = (sa != sb) ? sa : (sa ? ma > mb : ma < mb);
		if ((a[62:52] == 11'h7FF && a[51:0] != 52'h0) || (b[62:52] == 11'h7FF && b[51:0] != 52'h0))
			cmp_sd = 3'b111;
		else if (sa == sb && ma == mb)
			cmp_sd = 3'b100;
		else
			cmp_sd = lt ? 3'b001 : 3'b000;
	endfunction : cmp_sd

	// ************************************************
	// State
	// ************************************************
	logic [127:0] vreg [16];
	logic [63:0] pint [8];
	logic [31:0] area [256];

	eng_state_t st_r, st_nxt;
	logic [6:0] w_r, w_nxt;
	logic slot_r, slot_nxt;
	logic restore_r, restore_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [3:0] istat_r, istat_nxt;
	logic [3:0] imask_r, imask_nxt;
	logic [31:0] vcsr_r, vcsr_nxt;
	logic [31:0] flags_r, flags_nxt;
	logic [7:0] tag_r, tag_nxt;
	logic [63:0] gpr_r, gpr_nxt;
	logic fault_r, fault_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic irq_r, irq_nxt;

	vreg_wr_t vw;
	pint_wr_t pw;
	area_wr_t aw;

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb
	begin
		logic wr;
		logic long64;
		logic wide;
		logic [63:0] ea;
		logic [3:0] src_a;
		logic [3:0] src_b;
		logic [3:0] ev;
		logic [2:0] cf;
		logic [6:0] k;
		logic [6:0] j;
		logic [31:0] word;
		region_t rg;
		wr = psel && penable && pready_r && pwrite;
		rg = decode(paddr);
		long64 = exec_mode_t'(ctrl_r[`CTRL_MODE_LSB +: 3]) == MODE_LONG64;
		// Compatibility, protected, real and v86 all take the same path
		wide = long64 && ctrl_r[`CTRL_PREFIX_BIT] && ctrl_r[`CTRL_WIDTH_BIT];
		ea = wide ? gpr_r : {32'h0, gpr_r[31:0]};
		src_a = {long64 && ctrl_r[`CTRL_SRC_A_LSB + 3], ctrl_r[`CTRL_SRC_A_LSB +: 3]};
		src_b = {long64 && ctrl_r[`CTRL_SRC_B_LSB + 3], ctrl_r[`CTRL_SRC_B_LSB +: 3]};
		k = w_r - `W_PINT_FIRST;
		j = w_r - `W_VREG_FIRST;
		word = area[{slot_r, w_r}];
		ev = 4'h0;
		st_nxt = st_r;
		w_nxt = w_r;
		slot_nxt = slot_r;
		restore_nxt = restore_r;
		ctrl_nxt = ctrl_r;
		imask_nxt = imask_r;
		vcsr_nxt = vcsr_r;
		flags_nxt = flags_r;
		tag_nxt = tag_r;
		gpr_nxt = gpr_r;
		fault_nxt = fault_r;
		vw = '0;
		pw = '0;
		aw = '0;
		cf = cmp_sd(vreg[src_a][63:0], vreg[src_b][63:0], vcsr_r[`VCSR_DAZ]);

		// Bus side; the engine holds pready low, so no bus write meets it
		if (wr)
		begin
			unique case (rg)
				RG_VREG:
				begin
					vw = '{1'b1, paddr[7:4], lane_sel(paddr[3:2]), {4{pwdata}}};
				end
				RG_PINT:
				begin
					pw = '{1'b1, paddr[5:3], 2'b01 << paddr[2], {2{pwdata}}};
				end
				RG_AREA:
				begin
					aw = '{1'b1, paddr[9:2], pwdata};
				end
				RG_REG:
				begin
					unique case (paddr)
						`OFF_CTRL: ctrl_nxt = pwdata;
						`OFF_INT_MASK: imask_nxt = pwdata[3:0];
						`OFF_VCSR: vcsr_nxt = pwdata & `VCSR_LEGAL;
						`OFF_FLAGS: flags_nxt = pwdata;
						`OFF_TAG: tag_nxt = pwdata[7:0];
						`OFF_GPR_LO: gpr_nxt[31:0] = pwdata;
						`OFF_GPR_HI: gpr_nxt[63:32] = pwdata;
						`OFF_CMD:
						begin
							if (pwdata[`CMD_SAVE] || pwdata[`CMD_RESTORE])
							begin
								// Area must be 512-byte aligned inside the two slots
								if (ea[8:0] != 9'h0 || ea[63:10] != 54'h0)
								begin
									ev[`EV_FAULT] = 1'b1;
									fault_nxt = 1'b1;
								end
								else
								begin
									slot_nxt = ea[9];
									restore_nxt = !pwdata[`CMD_SAVE];
									w_nxt = 7'h0;
									fault_nxt = 1'b0;
									st_nxt = pwdata[`CMD_SAVE] ? ST_RUN : ST_CHECK;
								end
							end
							if (pwdata[`CMD_COMPARE])
							begin
								flags_nxt = flags_r & ~`FLAGS_CMP_MASK;
								flags_nxt[`FLAG_ZF] = cf[2];
								flags_nxt[`FLAG_PF] = cf[1];
								flags_nxt[`FLAG_CF] = cf[0];
								ev[`EV_COMPARE] = 1'b1;
							end
							if (pwdata[`CMD_MOVE])
							begin
								vw = '{1'b1, src_a, 4'hF, {64'h0, pint[src_b[2:0]]}};
							end
						end
						default:
						begin
						end
					endcase
				end
				default:
				begin
				end
			endcase
		end

		// Save and restore engine
		unique case (st_r)
			ST_IDLE:
			begin
			end
			ST_CHECK:
			begin
				if ((area[{slot_r, `W_VCSR}] & ~`VCSR_LEGAL) != 32'h0)
				begin
					ev[`EV_FAULT] = 1'b1;
					fault_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end
				else
				begin
					st_nxt = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (restore_r)
				begin
					if (w_r == `W_TAG)
						tag_nxt = word[7:0];
					if (w_r == `W_VCSR)
						vcsr_nxt = word;
					if (w_r >= `W_PINT_FIRST && w_r < `W_VREG_FIRST && !k[1])
						pw = '{1'b1, k[4:2], 2'b01 << k[0], {2{word}}};
					if (w_r >= `W_VREG_FIRST && (w_r < `W_VREG_HI || long64))
						vw = '{1'b1, j[5:2], lane_sel(j[1:0]), {4{word}}};
				end
				else
				begin
					aw.en = 1'b1;
					aw.idx = {slot_r, w_r};
					aw.data = 32'h0;
					if (w_r == `W_TAG)
						aw.data = {24'h0, tag_r};
					else if (w_r == `W_VCSR)
						aw.data = vcsr_r;
					else if (w_r == `W_VCSR_MASK)
						aw.data = `VCSR_LEGAL;
					else if (w_r >= `W_PINT_FIRST && w_r < `W_VREG_FIRST && !k[1])
						aw.data = pint[k[4:2]][32 * k[0] +: 32];
					else if (w_r >= `W_VREG_FIRST)
						aw.data = vreg[j[5:2]][32 * j[1:0] +: 32];
					if (w_r >= `W_VREG_HI && !long64)
						aw.en = 1'b0;
				end
				if (w_r == `W_LAST)
					st_nxt = ST_DONE;
				else
					w_nxt = w_r + 7'h1;
			end
			ST_DONE:
			begin
				ev[restore_r ? `EV_RESTORE : `EV_SAVE] = 1'b1;
				st_nxt = ST_IDLE;
			end
		endcase

		// New events win over a clear in the same cycle
		istat_nxt = istat_r;
		if (wr && rg == RG_REG && paddr == `OFF_INT_STAT)
			istat_nxt = istat_r & ~pwdata[3:0];
		istat_nxt = istat_nxt | ev;
		irq_nxt = (istat_nxt & imask_nxt) != 4'h0;

		// Bus answer: one wait state, none while the engine runs
		pready_nxt = psel && penable && !pready_r && st_r == ST_IDLE;
		pslverr_nxt = pready_nxt && rg == RG_NONE;
		prdata_nxt = prdata_r;
		if (pready_nxt)
		begin
			unique case (rg)
				RG_VREG: prdata_nxt = vreg[paddr[7:4]][32 * paddr[3:2] +: 32];
				RG_PINT: prdata_nxt = pint[paddr[5:3]][32 * paddr[2] +: 32];
				RG_AREA: prdata_nxt = area[paddr[9:2]];
				RG_REG:
				begin
					unique case (paddr)
						`OFF_CTRL: prdata_nxt = ctrl_r;
						`OFF_STATUS: prdata_nxt = {30'h0, fault_r, st_r != ST_IDLE};
						`OFF_INT_STAT: prdata_nxt = {28'h0, istat_r};
						`OFF_INT_MASK: prdata_nxt = {28'h0, imask_r};
						`OFF_VCSR: prdata_nxt = vcsr_r;
						`OFF_FEATURE: prdata_nxt = `FEATURE_VAL;
						`OFF_FLAGS: prdata_nxt = flags_r;
						`OFF_TAG: prdata_nxt = {24'h0, tag_r};
						`OFF_GPR_LO: prdata_nxt = gpr_r[31:0];
						`OFF_GPR_HI: prdata_nxt = gpr_r[63:32];
						default: prdata_nxt = 32'h0;
					endcase
				end
				default: prdata_nxt = 32'h0;
			endcase
		end
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= ST_IDLE;
			w_r <= 7'h0;
			slot_r <= 1'b0;
			restore_r <= 1'b0;
			ctrl_r <= 32'h0;
			istat_r <= 4'h0;
			imask_r <= 4'h0;
			vcsr_r <= `VCSR_RST;
			flags_r <= `FLAGS_RST;
			tag_r <= 8'h0;
			gpr_r <= 64'h0;
			fault_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
			irq_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			w_r <= w_nxt;
			slot_r <= slot_nxt;
			restore_r <= restore_nxt;
			ctrl_r <= ctrl_nxt;
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
			vcsr_r <= vcsr_nxt;
			flags_r <= flags_nxt;
			tag_r <= tag_nxt;
			gpr_r <= gpr_nxt;
			fault_r <= fault_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Arrays carry no reset; software, a save or a restore loads them
	always_ff @(posedge pclk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (vw.en && vw.lanes[i])
				vreg[vw.idx][32 * i +: 32] <= vw.data[32 * i +: 32];
		end
		for (int i = 0; i < 2; i++)
		begin
			if (pw.en && pw.lanes[i])
				pint[pw.idx][32 * i +: 32] <= pw.data[32 * i +: 32];
		end
		if (aw.en)
			area[aw.idx] <= aw.data;
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;

endmodule : simd_state_save_restore

/* File: verification/simd_state_save_restore_checker.sv */
`include "simd_consts.svh"

module simd_state_save_restore_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import simd_pkg::*;
	// ********
	// Bus and state properties
	// ********
	default clocking dck @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready held too long");
	property p_cause;
		pready |-> psel && penable;
	endproperty
	a_cause: assert property (p_cause) else $error("pready without access");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	// Longest wait is a save or restore still running
	property p_wait;
		psel && penable && !pready |-> ##[1:120] pready;
	endproperty
	a_wait: assert property (p_wait) else $error("no answer");
	property p_feature;
		pready && !pwrite && paddr == `OFF_FEATURE |-> prdata == `FEATURE_VAL;
	endproperty
	a_feature: assert property (p_feature) else $error("feature word wrong");
	property p_vcsr;
		pready && !pwrite && paddr == `OFF_VCSR |-> prdata[31:16] == 16'h0000;
	endproperty
	a_vcsr: assert property (p_vcsr) else $error("control word reserved bits");
	property p_unmap;
		pready && paddr[11:10] == 2'b11 |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_irq_fall;
		$fell(irq) |-> $past(pready && pwrite);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(irq));
	c_stall: cover property ((psel && penable && !pready) [*8]);
endmodule : simd_state_save_restore_checker

bind simd_state_save_restore simd_state_save_restore_checker chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

/* File: verification/apb_host_model.sv */
module apb_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
	end
	// Entered just after a rising edge; returns one edge after the answer
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines do not keep their last value
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask : xfer
endmodule : apb_host_model

/* File: verification/tb_simd_state_save_restore.sv */
`include "simd_consts.svh"

module tb_simd_state_save_restore;
	timeunit 1ns;
	timeprecision 1ps;
	import simd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int num_errors = 0;
	int checks = 0;
	always #5 pclk = ~pclk;
	simd_state_save_restore dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq);
	apb_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	// ********
	// Shared tasks
	// ********
	task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] s);
		checks++;
		if (s !== x)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, x, s);
		end
	endtask : cmp
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] x);
		host.xfer(1'b0, a, 32'h0, q, e);
		cmp(n, x, q);
	endtask : rc
	task automatic go(input logic [31:0] c, input logic [31:0] s);
		wr(`OFF_CMD, c);
		rc("int_stat", `OFF_INT_STAT, s);
		wr(`OFF_INT_STAT, s);
	endtask : go
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// ********
	// Scenarios
	// ********
	task automatic t_reset;
		rc("vcsr", `OFF_VCSR, `VCSR_RST);
		rc("flags", `OFF_FLAGS, `FLAGS_RST);
		wr(`OFF_FEATURE, 32'h0);
		rc("feature", `OFF_FEATURE, `FEATURE_VAL);
		rc("unmapped", 12'hC00, 32'h0);
		cmp("slverr", 32'h1, {31'h0, e});
	endtask : t_reset
	task automatic t_save;
		wr(`OFF_CTRL, 32'h2);
		wr(`OFF_TAG, 32'hA5);
		wr(`OFF_VCSR, 32'h1FC0);
		wr(12'h500, 32'h11223344);
		wr(12'h504, 32'h55667788);
		for (int i = 0; i < 4; i++)
			wr(12'(12'h400 + 4 * i), 32'hA0 + i);
		wr(12'h920, 32'hDEADBEEF);
		wr(`OFF_INT_MASK, 32'hF);
		wr(`OFF_CMD, 32'h1);
		rc("save done", `OFF_INT_STAT, 32'h1);
		cmp("irq", 32'h1, {31'h0, irq});
		rc("tag byte", 12'h804, 32'hA5);
		rc("area vcsr", 12'h818, 32'h1FC0);
		rc("area mask", 12'h81C, 32'h0000FFFF);
		rc("area pint", 12'h820, 32'h11223344);
		rc("area pint hi", 12'h824, 32'h55667788);
		for (int i = 0; i < 4; i++)
			rc("area vreg", 12'(12'h8A0 + 4 * i), 32'hA0 + i);
		rc("area hi vregs", 12'h920, 32'hDEADBEEF);
		wr(`OFF_INT_STAT, 32'h1);
		rc("cleared", `OFF_INT_STAT, 32'h0);
		cmp("irq", 32'h0, {31'h0, irq});
	endtask : t_save
	task automatic t_fault;
		wr(12'h818, 32'h00010000);
		wr(`OFF_INT_MASK, 32'h0);
		wr(`OFF_CMD, 32'h2);
		rc("fault", `OFF_INT_STAT, 32'h4);
		rc("status", `OFF_STATUS, 32'h2);
		cmp("masked irq", 32'h0, {31'h0, irq});
		wr(`OFF_INT_MASK, 32'h4);
		rc("vcsr kept", `OFF_VCSR, 32'h1FC0);
		cmp("irq", 32'h1, {31'h0, irq});
		wr(`OFF_INT_STAT, 32'h4);
	endtask : t_fault
	task automatic t_restore;
		wr(12'h818, 32'h1F80);
		wr(12'h804, 32'h3C);
		wr(12'h480, 32'h5A5A5A5A);
		go(32'h2, 32'h2);
		rc("vreg8 kept", 12'h480, 32'h5A5A5A5A);
		rc("vcsr", `OFF_VCSR, 32'h1F80);
		rc("tag", `OFF_TAG, 32'h3C);
		wr(`OFF_CTRL, 32'h4);
		go(32'h2, 32'h2);
		rc("vreg8", 12'h480, 32'hDEADBEEF);
	endtask : t_restore
	task automatic t_cmp(input logic [2:0] m, input logic [31:0] b, input logic [31:0] x);
		wr(`OFF_CTRL, {16'h0, 4'h1, 4'h0, 5'h0, m});
		wr(12'h414, b);
		wr(`OFF_CMD, 32'h4);
		rc("flags", `OFF_FLAGS, x);
	endtask : t_cmp
	task automatic t_compare;
		wr(12'h400, 32'h0);
		wr(12'h404, 32'h3FF00000);
		wr(12'h410, 32'h0);
		// High quadword is a NaN so any use of it would show
		wr(12'h41C, 32'h7FF80000);
		t_cmp(MODE_COMPAT, 32'h3FF00000, 32'h42);
		t_cmp(MODE_REAL, 32'h40000000, 32'h03);
		t_cmp(MODE_V86, 32'h3FE00000, 32'h02);
		t_cmp(MODE_PROT, 32'h7FF80000, 32'h47);
		t_cmp(MODE_LONG64, 32'h40000000, 32'h03);
		// Denormal against zero: equal only when denormals count as zero
		wr(`OFF_VCSR, 32'h1FC0);
		wr(12'h400, 32'h1);
		wr(12'h404, 32'h0);
		t_cmp(MODE_PROT, 32'h0, 32'h42);
		wr(`OFF_CTRL, 32'h202);
		wr(`OFF_CMD, 32'h8);
		rc("move lo", 12'h420, 32'h11223344);
		rc("move hi", 12'h424, 32'h55667788);
		rc("move upper", 12'h428, 32'h0);
	endtask : t_compare
	task automatic t_width;
		wr(`OFF_INT_STAT, 32'hF);
		wr(`OFF_GPR_HI, 32'h1);
		wr(`OFF_CTRL, 32'h1C);
		go(32'h1, 32'h4);
		wr(`OFF_CTRL, 32'h0C);
		wr(12'h480, 32'h13579BDF);
		go(32'h1, 32'h1);
		rc("area vreg8", 12'h920, 32'h13579BDF);
	endtask : t_width
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_save;
		t_fault;
		t_restore;
		t_compare;
		t_width;
		close_out;
	end
	initial
	begin
		#60us;
		num_errors++;
		close_out;
	end
endmodule : tb_simd_state_save_restore
